/* File: core/dbg_status_pkg.sv */
// Purpose: constants for the debug status and instruction injection block
// Assumes: register indices are chosen locally, the port carries an index
// Notes:   status bit positions follow the debug entry status layout
package dbg_status_pkg;
  localparam logic [1:0]  REG_STATUS      = 2'h0;
  localparam logic [1:0]  REG_INSTR       = 2'h1;
  localparam logic [1:0]  REG_PERIPH      = 2'h2;
  localparam logic [1:0]  REG_PC          = 2'h3;
  localparam int          BIT_TBUF_FULL   = 28;
  localparam int          BIT_EXT_EVENT   = 27;
  localparam int          BIT_REQ_ACK     = 26;
  localparam int          BIT_ZERO_OP     = 25;
  localparam int          BIT_HALTED      = 24;
  localparam int          BP_LSB          = 8;
  localparam int          BP_MSB          = 15;
  localparam int          BIT_OCD         = 5;
  localparam int          BIT_SLEEP       = 4;
  localparam int          BIT_HW_BREAK    = 2;
  localparam int          BIT_SW_BREAK    = 1;
  localparam int          BIT_SSTEP       = 0;
  localparam logic [31:0] RESET_WORD      = 32'h0000_0000;
  localparam logic [31:0] ZERO_OPCODE     = 32'h0000_0000;
endpackage : dbg_status_pkg

/* File: core/dbg_periph_gate.sv */
// Purpose: per-peripheral run/stop decision while the core is in debug
// Assumes: all inputs are on clk_sys
// Notes:   a set bit keeps the peripheral running in debug while run_in_debug_control is set
`timescale 1ns/10ps
module dbg_periph_gate #(
  parameter int N = 32
) (
  input  wire logic         clk_sys,     // system clock
  input  wire logic         reset_n,     // async reset, active low
  input  wire logic         run_in_debug_control, // run-in-debug enable
  input  wire logic         in_debug,    // core is in debug mode
  input  wire logic [N-1:0] periph_bits, // peripheral_halt_control
  output logic      [N-1:0] periph_stop  // per-peripheral stop, registered
);
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_per
      wire keep_run;
      assign keep_run = run_in_debug_control & in_debug & periph_bits[g];
      always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) periph_stop[g] <= 1'b0;
        else          periph_stop[g] <= in_debug & ~keep_run;
      end
    end
  endgenerate
endmodule : dbg_periph_gate

/* File: core/dbg_status_unit.sv */
// Purpose: debug entry status, injected instruction, peripheral halt control
//          and sampled program counter registers of the on-chip debug unit
// Assumes: core signals are on clk_sys; the event pin input is synchronised here
// Notes:   register access is a simple indexed strobe port from the debug port
//
// Contract
// - every simultaneous entry cause sets its bit
// - status read-only, tracks debug state itself
// - bit 28 trace buffer full cause
// - bit 27 external event input cause
// - bit 26 debug request or abort cause
// - bit 25 all-zero opcode cause
// - bit 24 halted in OCD, no execution
// - bits 15:8 per comparator hit flags
// - bit 5 set only in OCD mode
// - bit 4 OCD entered from sleep
// - bit 2 hardware breakpoint cause
// - bit 1 software breakpoint instruction cause
// - bit 0 single step cause
// - OCD mode executes the injected instruction
// - resume executes displaced instruction from register
// - peripheral runs only if enabled, debug, bit
// - pc register tracks last executed instruction
// - pc holds pre-entry address in debug
// - replaced return uses pc register as PC
// - replace bit fetches injected instruction once, clears
`timescale 1ns/10ps
module dbg_status_unit #(
  parameter int NUM_PERIPH = 32,
  parameter int NUM_BP     = 8
) (
  input  wire logic                  clk_sys,           // system clock
  input  wire logic                  reset_n,           // async reset, active low
  // register port
  input  wire logic [1:0]            reg_index,         // register index
  input  wire logic                  reg_write,         // write strobe, one cycle
  input  wire logic                  reg_read,          // read strobe, one cycle
  input  wire logic [31:0]           reg_wdata,         // write data
  output logic      [31:0]           reg_rdata,         // read data, registered
  output logic                       reg_rvalid,        // read data valid pulse
  // core side
  input  wire logic                  debug_enter,       // pulse: core enters debug
  input  wire logic                  debug_exit,        // pulse: core leaves debug
  input  wire logic                  ocd_mode,          // entry is OCD, not monitor
  input  wire logic                  cause_tbuf_full,   // trace buffer full cause
  input  wire logic                  external_event_input, // event pin, async
  input  wire logic                  event_break_en,    // event pin breaks enabled
  input  wire logic                  cause_request,     // debug request/abort cause
  input  wire logic                  cause_zero_opcode, // zero opcode trap cause
  input  wire logic [NUM_BP-1:0]     cause_comparator,  // comparator hits
  input  wire logic                  cause_sw_break,    // breakpoint instruction
  input  wire logic                  cause_single_step, // single step done
  input  wire logic                  core_sleeping,     // core in a sleep mode
  input  wire logic                  core_busy,         // instruction executing
  input  wire logic                  instr_retire,      // pulse: instruction retired
  input  wire logic [31:0]           retire_pc,         // PC of retired instruction
  input  wire logic                  instruction_replace_control, // replace bit
  input  wire logic                  replace_fetch,     // pulse: first fetch after exit
  input  wire logic                  run_in_debug_control, // run-in-debug enable
  output logic                       inject_valid,      // injected instruction pending
  output logic      [31:0]           inject_instr,      // instruction for the core
  output logic                       use_injected,      // fetch from injected register
  output logic                       replace_done,      // pulse: clear replace bit
  output logic      [31:0]           replace_pc,        // PC seen by replaced return
  output logic                       event_break,       // pulse: falling edge on event pin
  output logic      [NUM_PERIPH-1:0] periph_stop        // per-peripheral stop
);
  logic [31:0]            instr_q;
  logic [NUM_PERIPH-1:0]  periph_q;
  logic [31:0]            pc_q;
  logic                   in_debug_q;
  logic                   ocd_q;
  logic                   tbuf_q;
  logic                   ext_q;
  logic                   req_q;
  logic                   zop_q;
  logic                   sleep_q;
  logic                   hwb_q;
  logic                   swb_q;
  logic                   sss_q;
  logic [NUM_BP-1:0]      bp_q;
  logic                   pend_q;
  logic                   evt_s1_q;
  logic                   evt_s2_q;
  logic                   evt_s3_q;
  logic                   ext_hit_q;
  logic [31:0]            rdata_d;

  // the pin is asynchronous: two flops, then a third for falling edge detection
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      evt_s1_q <= 1'b1;
      evt_s2_q <= 1'b1;
      evt_s3_q <= 1'b1;
    end else begin
      evt_s1_q <= external_event_input;
      evt_s2_q <= evt_s1_q;
      evt_s3_q <= evt_s2_q;
    end
  end

  wire evt_fall;
  assign evt_fall    = evt_s3_q & ~evt_s2_q;
  assign event_break = evt_fall & event_break_en & ~in_debug_q;

  // remember an event break until the core actually enters debug
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ext_hit_q <= 1'b0;
    end else if (debug_enter) begin
      ext_hit_q <= 1'b0;
    end else if (event_break) begin
      ext_hit_q <= 1'b1;
    end
  end

  wire wr_instr, wr_periph, wr_pc;
  assign wr_instr  = reg_write & (reg_index == dbg_status_pkg::REG_INSTR);
  assign wr_periph = reg_write & (reg_index == dbg_status_pkg::REG_PERIPH);
  assign wr_pc     = reg_write & (reg_index == dbg_status_pkg::REG_PC);

  // all causes of one entry are latched together; an entry wins over a same-cycle exit
  wire   load_cause;
  wire   drop_cause;
  assign load_cause = debug_enter;
  assign drop_cause = debug_exit & ~debug_enter;

  // in debug from the entry pulse until the exit pulse
  wire   in_debug_d;
  assign in_debug_d = load_cause ? 1'b1 : drop_cause ? 1'b0 : in_debug_q;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      in_debug_q <= 1'b0;
    end else begin
      in_debug_q <= in_debug_d;
    end
  end

  // ocd entry as opposed to monitor entry
  wire   ocd_d;
  assign ocd_d = load_cause ? ocd_mode : drop_cause ? 1'b0 : ocd_q;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ocd_q <= 1'b0;
    end else begin
      ocd_q <= ocd_d;
    end
  end

  // trace buffer full
  wire   tbuf_d;
  assign tbuf_d = load_cause ? cause_tbuf_full : drop_cause ? 1'b0 : tbuf_q;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      tbuf_q <= 1'b0;
    end else begin
      tbuf_q <= tbuf_d;
    end
  end

  // event pin, also when its break lands in the entry cycle itself
  wire   ext_d;
  assign ext_d = load_cause ? (ext_hit_q | event_break) : drop_cause ? 1'b0 : ext_q;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ext_q <= 1'b0;
    end else begin
      ext_q <= ext_d;
    end
  end

  // debug request or abort
  wire   req_d;
  assign req_d = load_cause ? cause_request : drop_cause ? 1'b0 : req_q;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      req_q <= 1'b0;
    end else begin
      req_q <= req_d;
    end
  end

  // all-zero opcode trap
  wire   zop_d;
  assign zop_d = load_cause ? cause_zero_opcode : drop_cause ? 1'b0 : zop_q;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      zop_q <= 1'b0;
    end else begin
      zop_q <= zop_d;
    end
  end

  // comparator hits, comparator 0A in the lowest bit
  wire   [NUM_BP-1:0] bp_d;
  assign bp_d = load_cause ? cause_comparator : drop_cause ? {NUM_BP{1'b0}} : bp_q;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      bp_q <= '0;
    end else begin
      bp_q <= bp_d;
    end
  end

  // any comparator hit
  wire   hwb_d;
  assign hwb_d = load_cause ? (|cause_comparator) : drop_cause ? 1'b0 : hwb_q;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      hwb_q <= 1'b0;
    end else begin
      hwb_q <= hwb_d;
    end
  end

  // breakpoint instruction
  wire   swb_d;
  assign swb_d = load_cause ? cause_sw_break : drop_cause ? 1'b0 : swb_q;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      swb_q <= 1'b0;
    end else begin
      swb_q <= swb_d;
    end
  end

  // single step done
  wire   sss_d;
  assign sss_d = load_cause ? cause_single_step : drop_cause ? 1'b0 : sss_q;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sss_q <= 1'b0;
    end else begin
      sss_q <= sss_d;
    end
  end

  // monitor entries never report sleep, only ocd entries do
  wire   sleep_d;
  assign sleep_d = load_cause ? (ocd_mode & core_sleeping) : drop_cause ? 1'b0 : sleep_q;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sleep_q <= 1'b0;
    end else begin
      sleep_q <= sleep_d;
    end
  end

  // status word is assembled live from state, so it never needs clearing
  logic [31:0] status_w;
  always_comb begin
    status_w = dbg_status_pkg::RESET_WORD;
    status_w[dbg_status_pkg::BIT_TBUF_FULL] = tbuf_q;
    status_w[dbg_status_pkg::BIT_EXT_EVENT] = ext_q;
    status_w[dbg_status_pkg::BIT_REQ_ACK]   = req_q;
    status_w[dbg_status_pkg::BIT_ZERO_OP]   = zop_q;
    status_w[dbg_status_pkg::BIT_HALTED]    = ocd_q & ~core_busy & ~pend_q;
    status_w[dbg_status_pkg::BP_MSB:dbg_status_pkg::BP_LSB] = bp_q;
    status_w[dbg_status_pkg::BIT_OCD]       = ocd_q;
    status_w[dbg_status_pkg::BIT_SLEEP]     = sleep_q;
    status_w[dbg_status_pkg::BIT_HW_BREAK]  = hwb_q;
    status_w[dbg_status_pkg::BIT_SW_BREAK]  = swb_q;
    status_w[dbg_status_pkg::BIT_SSTEP]     = sss_q;
  end

  // injected instruction: a write while in OCD mode queues one execution
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      instr_q <= dbg_status_pkg::RESET_WORD;
    end else if (wr_instr) begin
      instr_q <= reg_wdata;
    end
  end

  // pending flag: new write wins over the core consuming the previous one
  wire consume;
  assign consume = pend_q & ocd_q & ~core_busy;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pend_q <= 1'b0;
    end else if (wr_instr & ocd_q) begin
      pend_q <= 1'b1;
    end else if (consume | ~ocd_q) begin
      pend_q <= 1'b0;
    end
  end

  assign inject_valid = pend_q;
  assign inject_instr = instr_q;

  // replace: first fetch after exit comes from the injected register once
  assign use_injected = instruction_replace_control & ~in_debug_q & replace_fetch;
  assign replace_done = use_injected;
  assign replace_pc   = pc_q;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      periph_q <= '0;
    end else if (wr_periph) begin
      periph_q <= reg_wdata[NUM_PERIPH-1:0];
    end
  end

  // pc tracks retirement only outside debug, so it freezes at the pre-entry value;
  // a debugger write is kept for the replaced return sequence
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pc_q <= dbg_status_pkg::RESET_WORD;
    end else if (wr_pc) begin
      pc_q <= reg_wdata;
    end else if (instr_retire & ~in_debug_q) begin
      pc_q <= retire_pc;
    end
  end

  // reads only select, no state changes on a read
  always_comb begin
    case (reg_index)
      dbg_status_pkg::REG_STATUS: rdata_d = status_w;
      dbg_status_pkg::REG_INSTR:  rdata_d = instr_q;
      dbg_status_pkg::REG_PERIPH: rdata_d = 32'(periph_q);
      dbg_status_pkg::REG_PC:     rdata_d = pc_q;
      default:                    rdata_d = dbg_status_pkg::RESET_WORD;
    endcase
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata  <= dbg_status_pkg::RESET_WORD;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_read;
      if (reg_read) reg_rdata <= rdata_d;
    end
  end

  dbg_periph_gate #(
    .N (NUM_PERIPH)
  ) u_gate (
    .clk_sys              (clk_sys),
    .reset_n              (reset_n),
    .run_in_debug_control (run_in_debug_control),
    .in_debug             (in_debug_q),
    .periph_bits          (periph_q),
    .periph_stop          (periph_stop)
  );
endmodule : dbg_status_unit

/* File: tb/dbg_status_unit_asserts.sv */
// Purpose: port-level checks on the debug status and injection block
// Assumes: single clk_sys domain, reset_n async active low
// Notes:   tracks debug state from the enter and exit pulses
`timescale 1ns/10ps
module dbg_status_unit_asserts #(
  parameter int NUM_PERIPH = 32
) (
  input wire logic                  clk_sys,                     // clock
  input wire logic                  reset_n,                     // reset
  input wire logic [1:0]            reg_index,                   // index
  input wire logic                  reg_write,                   // write strobe
  input wire logic                  reg_read,                    // read strobe
  input wire logic [31:0]           reg_wdata,                   // write data
  input wire logic [31:0]           reg_rdata,                   // read data
  input wire logic                  reg_rvalid,                  // read valid
  input wire logic                  debug_enter,                 // entry pulse
  input wire logic                  debug_exit,                  // exit pulse
  input wire logic                  event_break_en,              // event enable
  input wire logic                  instr_retire,                // retire pulse
  input wire logic [31:0]           retire_pc,                   // retired pc
  input wire logic                  instruction_replace_control, // replace bit
  input wire logic                  replace_fetch,               // first fetch
  input wire logic                  run_in_debug_control,        // run enable
  input wire logic [31:0]           inject_instr,                // injected word
  input wire logic                  use_injected,                // use injected
  input wire logic                  replace_done,                // clear pulse
  input wire logic [31:0]           replace_pc,                  // pc register
  input wire logic                  event_break,                 // event pulse
  input wire logic [NUM_PERIPH-1:0] periph_stop                  // stop flags
);
  logic in_dbg_q;
  logic in_dbg_d;
  logic pc_wr;
  assign in_dbg_d = debug_enter | (in_dbg_q & ~debug_exit);
  assign pc_wr    = reg_write && reg_index == dbg_status_pkg::REG_PC;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) in_dbg_q <= 1'b0;
    else in_dbg_q <= in_dbg_d;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  AST_READ_ANS: assert property (reg_read |=> reg_rvalid) else $error("read not answered");
  AST_RVALID: assert property (reg_rvalid |-> $past(reg_read)) else $error("spurious rvalid");
  AST_RSVD: assert property (reg_rvalid && $past(reg_index) == dbg_status_pkg::REG_STATUS
    |-> reg_rdata[31:29] == 3'h0 && reg_rdata[23:16] == 8'h00 && reg_rdata[7:6] == 2'h0
    && !reg_rdata[3]) else $error("reserved status bit set");
  AST_REPL: assert property (use_injected |-> instruction_replace_control && replace_fetch
    && replace_done) else $error("replace without cause");
  AST_INSTR: assert property (reg_write && reg_index == dbg_status_pkg::REG_INSTR
    |=> inject_instr == $past(reg_wdata)) else $error("injected word not stored");
  AST_PC_WR: assert property (pc_wr |=> replace_pc == $past(reg_wdata))
    else $error("pc write lost");
  AST_PC_HOLD: assert property (in_dbg_q && !pc_wr |=> $stable(replace_pc))
    else $error("pc moved in debug");
  AST_PC_RETIRE: assert property (!in_dbg_q && !debug_enter && instr_retire && !pc_wr
    |=> replace_pc == $past(retire_pc)) else $error("pc not captured");
  AST_STOP_OUT: assert property ((!in_dbg_q)[*3] |-> periph_stop == '0)
    else $error("stop outside debug");
  AST_STOP_NORID: assert property ((in_dbg_q && !run_in_debug_control)[*3] |-> &periph_stop)
    else $error("runs without enable");
  AST_EVT: assert property (event_break |-> event_break_en && !in_dbg_q)
    else $error("event break unexpected");
  cover property (reg_rvalid);
  cover property (use_injected);
  cover property (event_break);
  cover property (in_dbg_q && run_in_debug_control && !(&periph_stop));
endmodule : dbg_status_unit_asserts
bind dbg_status_unit dbg_status_unit_asserts #(.NUM_PERIPH(NUM_PERIPH)) chk_u (.*);

/* File: tb/dbg_host_model.sv */
// Purpose: debugger side of the indexed register port
// Assumes: strobes change 1 ns after a rising edge
// Notes:   idle write data is inverted so stale values never look valid
`timescale 1ns/10ps
module dbg_host_model (
  input  wire logic        clk_sys,    // clock
  output logic      [1:0]  reg_index,  // index
  output logic             reg_write,  // write strobe
  output logic             reg_read,   // read strobe
  output logic      [31:0] reg_wdata,  // write data
  input  wire logic [31:0] reg_rdata,  // read data
  input  wire logic        reg_rvalid  // read valid
);
  initial begin
    reg_index = 2'h0;
    reg_write = 1'b0;
    reg_read  = 1'b0;
    reg_wdata = 32'h0000_0000;
  end
  task automatic wr(input logic [1:0] i, input logic [31:0] d);
    @(posedge clk_sys);
    #1 reg_index = i;
    reg_wdata = d;
    reg_write = 1'b1;
    @(posedge clk_sys);
    #1 reg_write = 1'b0;
    reg_wdata = ~d;
  endtask : wr
  // status is read by the bench after reset and while in debug; outside debug it reads zero
  task automatic rd(input logic [1:0] i, output logic [31:0] d);
    @(posedge clk_sys);
    #1 reg_index = i;
    reg_read = 1'b1;
    @(posedge clk_sys);
    #1 reg_read = 1'b0;
    d = 'x;
    for (int k = 0; k < 4; k++) begin
      if (reg_rvalid === 1'b1) begin
        d = reg_rdata;
        break;
      end
      @(posedge clk_sys);
      #1;
    end
  endtask : rd
endmodule : dbg_host_model

/* File: tb/debug_status_and_injection_tb.sv */
// Purpose: random and corner stimulus for the debug status block
// Assumes: a missing read answer returns unknown and so counts as a mismatch
// Notes:   lfsr seeded with 5 keeps runs repeatable
`timescale 1ns/10ps
module debug_status_and_injection_tb;
  logic clk_sys = 0, reset_n = 0, debug_enter = 0, debug_exit = 0, ocd_mode = 0;
  logic cause_tbuf_full = 0, external_event_input = 1, event_break_en = 0, cause_request = 0;
  logic cause_zero_opcode = 0, cause_sw_break = 0, cause_single_step = 0, core_sleeping = 0;
  logic core_busy = 0, instr_retire = 0, instruction_replace_control = 0, replace_fetch = 0;
  logic run_in_debug_control = 0, reg_write, reg_read, reg_rvalid, inject_valid;
  logic use_injected, replace_done, event_break;
  logic [1:0]  reg_index;
  logic [7:0]  cause_comparator = 0, bp;
  logic [15:0] lfsr = 16'h0005, c;
  logic [31:0] reg_wdata, reg_rdata, retire_pc = 0, inject_instr, replace_pc, periph_stop;
  logic [31:0] rdv, p, pc;
  int          error_cnt = 0, n_compared = 0;
  always #10 clk_sys = ~clk_sys;
  dbg_status_unit dut_u (.*);
  dbg_host_model host_u (.*);
  function automatic logic [31:0] rnd();
    repeat (32) lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return {lfsr, lfsr[7:0], lfsr[15:8]};
  endfunction : rnd
  function automatic logic [31:0] exp_status(logic [15:0] c, logic [7:0] bp, logic ev);
    exp_status = {3'h0, c[0], ev, c[1], c[2], c[6] & ~c[7], 8'h00, bp, 2'h0, c[6],
                  c[6] & c[5], 1'b0, |bp, c[3], c[4]};
  endfunction : exp_status
  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic cyc(int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : cyc
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : print_verdict
  initial begin
    cyc(12);
    reset_n = 1;
    for (int i = 0; i < 4; i++) begin
      host_u.rd(i[1:0], rdv);
      chk("reset value", rdv, 32'h0000_0000);
    end
    for (int k = 0; k < 12; k++) begin
      p  = rnd();
      c  = (k == 0) ? 16'h037F : p[15:0];
      bp = (k == 0) ? 8'hFF : p[23:16];
      event_break_en = c[8];
      external_event_input = ~c[9];
      cyc(4);
      external_event_input = 1;
      {core_sleeping, cause_single_step, cause_sw_break, cause_zero_opcode} = c[5:2];
      {ocd_mode, cause_request, cause_tbuf_full, cause_comparator} = {c[6], c[1:0], bp};
      debug_enter = 1;
      cyc(1);
      debug_enter = 0;
      core_busy = c[7];
      host_u.wr(dbg_status_pkg::REG_STATUS, rnd());
      host_u.rd(dbg_status_pkg::REG_STATUS, rdv);
      chk("status", rdv, exp_status(c, bp, c[8] & c[9]));
      p = rnd();
      host_u.wr(dbg_status_pkg::REG_PERIPH, p);
      run_in_debug_control = c[10];
      cyc(3);
      chk("stop in debug", periph_stop, c[10] ? ~p : 32'hFFFF_FFFF);
      {instr_retire, retire_pc} = {1'b1, rnd()};
      cyc(1);
      instr_retire = 0;
      host_u.rd(dbg_status_pkg::REG_PC, rdv);
      if (k > 0) chk("pc in debug", rdv, pc);
      {debug_exit, core_busy} = 2'b10;
      cyc(1);
      debug_exit = 0;
      cyc(3);
      chk("stop outside", periph_stop, 32'h0000_0000);
      pc = rnd();
      {instr_retire, retire_pc} = {1'b1, pc};
      cyc(1);
      instr_retire = 0;
      host_u.rd(dbg_status_pkg::REG_PC, rdv);
      chk("pc sampled", rdv, pc);
    end
    {ocd_mode, debug_enter} = 2'b11;
    cyc(1);
    debug_enter = 0;
    p  = rnd();
    pc = rnd();
    core_busy = 1;
    host_u.wr(dbg_status_pkg::REG_INSTR, p);
    chk("inject pending", {31'h0, inject_valid}, 32'h0000_0001);
    core_busy = 0;
    cyc(1);
    chk("inject taken", {31'h0, inject_valid}, 32'h0000_0000);
    host_u.wr(dbg_status_pkg::REG_PC, pc);
    host_u.rd(dbg_status_pkg::REG_PC, rdv);
    chk("pc written", rdv, pc);
    chk("replace pc", replace_pc, pc);
    {instruction_replace_control, debug_exit} = 2'b11;
    cyc(1);
    debug_exit = 0;
    cyc(2);
    replace_fetch = 1;
    #1 chk("use injected", {31'h0, use_injected}, 32'h0000_0001);
    chk("injected word", inject_instr, p);
    chk("replace done", {31'h0, replace_done}, 32'h0000_0001);
    cyc(1);
    {replace_fetch, instruction_replace_control} = 2'b00;
    cyc(2);
    print_verdict();
  end
endmodule : debug_status_and_injection_tb
